/* rtl/ufeam_map.vh */
// Register addresses, bit positions and reset values of the serial add-ons
`ifndef UFEAM_MAP_VH
`define UFEAM_MAP_VH
`define UFEAM_ADDR_SERIAL_CTRL 8'h98
`define UFEAM_ADDR_SERIAL_CTRL1 8'hC0
`define UFEAM_ADDR_POWER_CTRL 8'h87
`define UFEAM_ADDR_STATION 8'hA9
`define UFEAM_ADDR_STATION_MASK 8'hB9
`define UFEAM_ADDR_STATION1 8'hAA
`define UFEAM_ADDR_STATION_MASK1 8'hBA
`define UFEAM_BIT_SHARED 7
`define UFEAM_BIT_FILTER_EN 5
`define UFEAM_BIT_RX_NINTH 2
`define UFEAM_BIT_RX_DONE 0
`define UFEAM_BIT_VIEW_SEL 6
`define UFEAM_RST_BYTE 8'h00
`define UFEAM_MODE_ONE 2'h1
`endif

/* rtl/ufeam_top.v */
// Framing error flag and station address filter for two serial ports
`timescale 1ns/1ps
`include "ufeam_map.vh"

// Contract
// - Missing stop bit raises framing error
// - Control bit 7 shows mode or error
// - View select 1 error, 0 mode bit
// - Hardware sets error; software write clears it only while view select is 1
// - Good frames never clear the error
// - Ninth bit high marks address frames
// - Filter on: done only on address match
// - Filter off: done on every frame
// - Mode 1 stop bit acts as ninth
// - Given address compares masked positions only
// - Broadcast is address OR mask, zeros ignored
// - Station at A9h/AAh, mask at B9h/BAh (ports 0/1)
// - Address and mask reset to zero
// - Load only if done clear, filter ok
// - Nine-bit modes store received ninth bit
module ufeam_top #(
	parameter NPORT = 2
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire [7:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	input wire [NPORT-1:0] frame_valid_i,
	input wire [NPORT*8-1:0] frame_data_i,
	input wire [NPORT-1:0] frame_bit9_i,
	input wire [NPORT-1:0] frame_stop_i,
	input wire [NPORT*2-1:0] port_mode_i,
	output reg [NPORT*8-1:0] serial_data_buffer_o,
	output reg [NPORT-1:0] rx_ninth_bit_o,
	output reg [NPORT-1:0] rx_done_flag_o,
	output reg [NPORT-1:0] mode_select_hi_o,
	output reg [NPORT-1:0] addr_filter_enable_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function addr_match;
		input [7:0] rx;
		input [7:0] sa;
		input [7:0] mk;
		reg [7:0] bc;
		begin
			bc = sa | mk;
			addr_match = (((rx ^ sa) & mk) == 8'h00) ||
				(((rx ^ bc) & bc) == 8'h00);
		end
	endfunction

	function [7:0] ctrl_addr;
		input integer p;
		begin
			ctrl_addr = (p == 0) ? `UFEAM_ADDR_SERIAL_CTRL :
				`UFEAM_ADDR_SERIAL_CTRL1;
		end
	endfunction

	function [7:0] sta_addr;
		input integer p;
		begin
			sta_addr = (p == 0) ? `UFEAM_ADDR_STATION :
				`UFEAM_ADDR_STATION1;
		end
	endfunction

	function [7:0] msk_addr;
		input integer p;
		begin
			msk_addr = (p == 0) ? `UFEAM_ADDR_STATION_MASK :
				`UFEAM_ADDR_STATION_MASK1;
		end
	endfunction

	function is_mode_one;
		input [1:0] md;
		begin
			is_mode_one = (md == `UFEAM_MODE_ONE);
		end
	endfunction

	function frame_accept;
		input done;
		input filt;
		input mode_one;
		input bit9;
		input stop;
		input match;
		begin
			frame_accept = !done &&
				(!filt || (stop && match && (mode_one || bit9)));
		end
	endfunction

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg flag_view_select;
	reg [NPORT-1:0] frame_err_flag;
	reg [7:0] station_address [0:NPORT-1];
	reg [7:0] station_address_mask [0:NPORT-1];
	reg [7:0] next_rdata;
	integer i;
	integer j;

	// ----------------------------------------
	// Register writes and receive events
	// ----------------------------------------
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_view_select <= 1'b0;
			frame_err_flag <= {NPORT{1'b0}};
			mode_select_hi_o <= {NPORT{1'b0}};
			addr_filter_enable_o <= {NPORT{1'b0}};
			rx_done_flag_o <= {NPORT{1'b0}};
			rx_ninth_bit_o <= {NPORT{1'b0}};
			serial_data_buffer_o <= {(NPORT*8){1'b0}};
			for (i = 0; i < NPORT; i = i + 1) begin
				station_address[i] <= `UFEAM_RST_BYTE;
				station_address_mask[i] <= `UFEAM_RST_BYTE;
			end
		end else begin
			if (reg_wr_i && reg_addr_i == `UFEAM_ADDR_POWER_CTRL) begin
				flag_view_select <= reg_wdata_i[`UFEAM_BIT_VIEW_SEL];
			end
			for (i = 0; i < NPORT; i = i + 1) begin
				if (reg_wr_i && reg_addr_i == ctrl_addr(i)) begin
					if (flag_view_select) begin
						frame_err_flag[i] <= reg_wdata_i[`UFEAM_BIT_SHARED];
					end else begin
						mode_select_hi_o[i] <= reg_wdata_i[`UFEAM_BIT_SHARED];
					end
					addr_filter_enable_o[i] <=
						reg_wdata_i[`UFEAM_BIT_FILTER_EN];
					rx_ninth_bit_o[i] <= reg_wdata_i[`UFEAM_BIT_RX_NINTH];
					rx_done_flag_o[i] <= reg_wdata_i[`UFEAM_BIT_RX_DONE];
				end
				if (reg_wr_i && reg_addr_i == sta_addr(i)) begin
					station_address[i] <= reg_wdata_i;
				end
				if (reg_wr_i && reg_addr_i == msk_addr(i)) begin
					station_address_mask[i] <= reg_wdata_i;
				end
				if (frame_valid_i[i]) begin
					if (!frame_stop_i[i]) begin
						frame_err_flag[i] <= 1'b1;
					end
					if (frame_accept(rx_done_flag_o[i],
						addr_filter_enable_o[i],
						is_mode_one(port_mode_i[i*2 +: 2]),
						frame_bit9_i[i], frame_stop_i[i],
						addr_match(frame_data_i[i*8 +: 8],
						station_address[i],
						station_address_mask[i]))) begin
						serial_data_buffer_o[i*8 +: 8] <=
							frame_data_i[i*8 +: 8];
						rx_ninth_bit_o[i] <=
							is_mode_one(port_mode_i[i*2 +: 2]) ?
							frame_stop_i[i] : frame_bit9_i[i];
						rx_done_flag_o[i] <= 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @* begin
		next_rdata = 8'h00;
		if (reg_addr_i == `UFEAM_ADDR_POWER_CTRL) begin
			next_rdata[`UFEAM_BIT_VIEW_SEL] = flag_view_select;
		end
		for (j = 0; j < NPORT; j = j + 1) begin
			if (reg_addr_i == ctrl_addr(j)) begin
				next_rdata[`UFEAM_BIT_SHARED] = flag_view_select ?
					frame_err_flag[j] : mode_select_hi_o[j];
				next_rdata[`UFEAM_BIT_FILTER_EN] = addr_filter_enable_o[j];
				next_rdata[`UFEAM_BIT_RX_NINTH] = rx_ninth_bit_o[j];
				next_rdata[`UFEAM_BIT_RX_DONE] = rx_done_flag_o[j];
			end
			if (reg_addr_i == sta_addr(j)) begin
				next_rdata = station_address[j];
			end
			if (reg_addr_i == msk_addr(j)) begin
				next_rdata = station_address_mask[j];
			end
		end
	end

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= `UFEAM_RST_BYTE;
		end else begin
			reg_rdata_o <= next_rdata;
		end
	end

endmodule // ufeam_top

/* sim/ufeam_props_properties.sv */
// Port 0 receive checks and a reset check of both ports
`timescale 1ns/1ps
module ufeam_props #(
	parameter NPORT = 2
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire reg_wr_i,
	input wire [NPORT-1:0] frame_valid_i,
	input wire [NPORT*8-1:0] frame_data_i,
	input wire [NPORT-1:0] frame_bit9_i,
	input wire [NPORT-1:0] frame_stop_i,
	input wire [NPORT*2-1:0] port_mode_i,
	input wire [NPORT*8-1:0] serial_data_buffer_o,
	input wire [NPORT-1:0] rx_ninth_bit_o,
	input wire [NPORT-1:0] rx_done_flag_o,
	input wire [NPORT-1:0] mode_select_hi_o,
	input wire [NPORT-1:0] addr_filter_enable_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		frame_valid_i[0] && !rx_done_flag_o[0] && !reg_wr_i;
	endsequence
	sequence s_open;
		s_take ##0 !addr_filter_enable_o[0];
	endsequence
	sequence s_shut;
		s_take ##0 addr_filter_enable_o[0];
	endsequence
	a_done_open: assert property (s_open |=> rx_done_flag_o[0])
		else $error("done");
	a_byte_load: assert property (s_open |=>
		serial_data_buffer_o[7:0] == $past(frame_data_i[7:0])) else $error("load");
	a_ninth_bit: assert property (s_open ##0 port_mode_i[1:0] != 2'h1 |=>
		rx_ninth_bit_o[0] == $past(frame_bit9_i[0])) else $error("ninth");
	a_stop_ninth: assert property (s_open ##0 port_mode_i[1:0] == 2'h1 |=>
		rx_ninth_bit_o[0] == $past(frame_stop_i[0])) else $error("stop");
	a_held_byte: assert property (frame_valid_i[0] && rx_done_flag_o[0] |=>
		$stable(serial_data_buffer_o[7:0])) else $error("held");
	a_mode1_drop: assert property (s_shut ##0 port_mode_i[1:0] == 2'h1
		&& !frame_stop_i[0] |=> !rx_done_flag_o[0]) else $error("filt");
	a_data_drop: assert property (s_shut ##0 port_mode_i[1:0] != 2'h1
		&& !frame_bit9_i[0] |=> !rx_done_flag_o[0]) else $error("addr");
	a_reset_zero: assert property ($fell(rst_i) |->
		mode_select_hi_o == 0 && rx_done_flag_o == 0) else $error("rst");
endmodule // ufeam_props
bind ufeam_top ufeam_props #(.NPORT(NPORT)) u_props (.*);

/* sim/ufeam_peer.sv */
// Far-side sender of port 0 frames
`timescale 1ns/1ps
module ufeam_peer (
	input wire core_clk_i,
	output reg v_o = 1'b0,
	output reg [7:0] d_o = 8'h00,
	output reg b9_o = 1'b0,
	output reg st_o = 1'b1
);
	task send(input [7:0] d, input b9, input st);
		begin
			@(posedge core_clk_i);
			v_o <= 1'b1;
			d_o <= d;
			b9_o <= b9;
			st_o <= st;
			@(posedge core_clk_i);
			v_o <= 1'b0;
			d_o <= ~d;
			b9_o <= ~b9;
			st_o <= ~st;
		end
	endtask
endmodule // ufeam_peer

/* sim/test_ufeam_top.sv */
// Bench for the serial add-ons
`timescale 1ns/1ps
module test_ufeam_top;
	reg clk = 1'b0;
	reg rst_i = 1'b1;
	reg [7:0] a = 8'h00;
	reg wr = 1'b0;
	reg [7:0] wd = 8'h00;
	reg [3:0] md = 4'h2;
	reg [31:0] tab = 32'h24FFA2A0;
	wire [7:0] rdat;
	wire v;
	wire [7:0] fd;
	wire b9;
	wire st;
	wire [15:0] bo;
	wire [1:0] nin;
	wire [1:0] dn;
	wire [1:0] msh;
	wire [1:0] fen;
	integer err_total = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer i;
	initial forever #10 clk = ~clk;
	ufeam_peer u_peer (.core_clk_i(clk), .v_o(v), .d_o(fd), .b9_o(b9), .st_o(st));
	ufeam_top u_dut (.core_clk_i(clk), .rst_i(rst_i), .reg_addr_i(a),
		.reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
		.frame_valid_i({1'b0, v}), .frame_data_i({8'h00, fd}),
		.frame_bit9_i({1'b0, b9}), .frame_stop_i({1'b1, st}),
		.port_mode_i(md), .serial_data_buffer_o(bo), .rx_ninth_bit_o(nin),
		.rx_done_flag_o(dn), .mode_select_hi_o(msh),
		.addr_filter_enable_o(fen));
	task chk(input [7:0] s, input [7:0] e);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0t got %h want %h", $time, s, e);
			end
		end
	endtask
	task w(input [7:0] ad, input [7:0] d);
		begin
			@(posedge clk);
			a <= ad;
			wd <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task r(input [7:0] ad, input [7:0] m, input [7:0] e);
		begin
			@(posedge clk);
			a <= ad;
			@(posedge clk);
			#1 chk(rdat & m, e);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d errors %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total = err_total + 1;
			complete_run;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_i <= 1'b0;
		r(8'hA9, 8'hFF, 8'h00);
		r(8'hB9, 8'hFF, 8'h00);
		r(8'h98, 8'h81, 8'h00);
		w(8'hA9, 8'hA4);
		w(8'hB9, 8'hFA);
		r(8'hA9, 8'hFF, 8'hA4);
		r(8'hB9, 8'hFF, 8'hFA);
		r(8'hAA, 8'hFF, 8'h00);
		r(8'hBA, 8'hFF, 8'h00);
		w(8'hAA, 8'h5C);
		r(8'hAA, 8'hFF, 8'h5C);
		r(8'hA9, 8'hFF, 8'hA4);
		$display("reset and station done");
		w(8'h87, 8'h40);
		u_peer.send(8'h5A, 1'b1, 1'b0);
		#1 chk(bo[7:0], 8'h5A);
		r(8'h98, 8'h85, 8'h85);
		u_peer.send(8'h33, 1'b0, 1'b1);
		#1 chk(bo[7:0], 8'h5A);
		r(8'h98, 8'h80, 8'h80);
		w(8'h98, 8'h00);
		r(8'h98, 8'h81, 8'h00);
		w(8'h87, 8'h00);
		w(8'h98, 8'h80);
		#1 chk(msh[0], 8'h01);
		r(8'h98, 8'h80, 8'h80);
		w(8'h87, 8'h40);
		r(8'h98, 8'h80, 8'h00);
		$display("flag view done");
		w(8'h98, 8'h20);
		#1 chk(fen[0], 8'h01);
		for (i = 0; i < 4; i = i + 1) begin
			u_peer.send(tab[i*8+:8], 1'b1, 1'b1);
			#1 chk(dn[0], {7'h00, ~i[0]});
			w(8'h98, 8'h20);
		end
		u_peer.send(8'hA0, 1'b0, 1'b1);
		#1 chk(dn[0], 8'h00);
		@(posedge clk) md <= 4'h1;
		u_peer.send(8'hFF, 1'b0, 1'b0);
		#1 chk(dn[0], 8'h00);
		r(8'h98, 8'h80, 8'h80);
		u_peer.send(8'h24, 1'b0, 1'b1);
		#1 chk(dn[0], 8'h00);
		u_peer.send(8'hA0, 1'b0, 1'b1);
		#1 chk(dn[0], 8'h01);
		w(8'h98, 8'h00);
		u_peer.send(8'h11, 1'b0, 1'b1);
		#1 chk(nin[0], 8'h01);
		$display("filter done");
		complete_run;
	end
endmodule // test_ufeam_top
